// ### include/lpd_defines.vh
`ifndef LPD_DEFINES_VH
`define LPD_DEFINES_VH
// =====================================================================
// Entry bit positions
`define LPD_BIT_READ 0
`define LPD_BIT_WRITE 1
`define LPD_BIT_EXEC 2
`define LPD_EMT_LO 3
`define LPD_EMT_HI 5
`define LPD_BIT_SKIP_ATTR_TABLE_BIT 6
`define LPD_BIT_PS 7
`define LPD_BIT_SNP 11
`define LPD_RSV_LO 12
`define LPD_RSV_HI 20
`define LPD_ADDR_LO 21
`define LPD_RSV_TOP 51
`define LPD_BIT_TM 62
// =====================================================================
// Memory type codes
`define LPD_MT_UC 3'h0
`define LPD_MT_WC 3'h1
`define LPD_MT_WT 3'h4
`define LPD_MT_WP 3'h5
`define LPD_MT_WB 3'h6
// =====================================================================
// Wishbone register map
`define LPD_REG_ENTRY_LO 6'h00
`define LPD_REG_ENTRY_HI 6'h04
`define LPD_REG_CTRL 6'h08
`define LPD_REG_STATUS 6'h0c
`define LPD_REG_ADDR_LO 6'h10
`define LPD_REG_ADDR_HI 6'h14
`define LPD_REG_ATTR 6'h18
// Control field positions
`define LPD_CTL_SC 0
`define LPD_CTL_DT 1
`define LPD_CTL_ZLR 2
`define LPD_CTL_SECOND_LEVEL_EXEC_ENABLE 3
`define LPD_CTL_EXT_MEM_TYPE_ENABLE 4
`define LPD_CTL_PASID 5
`define LPD_CTL_XLAT 6
`define LPD_CTL_NESTED 7
`define LPD_CTL_COHDOM 8
`define LPD_CTL_NS 9
`define LPD_CTL_ZLEN 10
`define LPD_CTL_ISWR 11
`define LPD_CTL_ISEX 12
`define LPD_CTL_RST 32'h0000_0000
`endif

// ### design/lpd_memtype.v
`include "lpd_defines.vh"
module lpd_memtype (
   input wire [2:0] code_i,
   input wire use_i,
   input wire skip_pat_i,
   output wire [2:0] mem_type_o,
   output wire type_rsv_o,
   output wire skip_attr_table_o,
   output wire apply_o
);
   // =====================================================================
   // Memory type decode
   function is_legal;
      input [2:0] c;
      begin
         is_legal = (c == `LPD_MT_UC) || (c == `LPD_MT_WC) || (c == `LPD_MT_WT) ||
                    (c == `LPD_MT_WP) || (c == `LPD_MT_WB);
      end
   endfunction
   assign apply_o = use_i;
   assign mem_type_o = use_i ? code_i : `LPD_MT_UC;
   assign type_rsv_o = use_i & ~is_legal(code_i);
   assign skip_attr_table_o = use_i & skip_pat_i;
endmodule // lpd_memtype

// ### design/lpd_decode.v
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`include "lpd_defines.vh"
module lpd_decode #(
   parameter HOST_ADDR_WIDTH = 39
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [5:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   output wire wb_err_o
);
   // =====================================================================
   // Registers
   reg [63:0] entry_ff;
   reg [31:0] ctrl_ff;
   reg ack_ff;
   reg err_ff;
   reg [63:0] addr_res_ff;
   reg [31:0] status_ff;
   reg [31:0] attr_ff;
   wire req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0] sel;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
               merge[k*8 +: 8] = dat[k*8 +: 8];
            end
         end
      end
   endfunction
   wire mapped = (wb_adr_i == `LPD_REG_ENTRY_LO) || (wb_adr_i == `LPD_REG_ENTRY_HI) ||
                 (wb_adr_i == `LPD_REG_CTRL) || (wb_adr_i == `LPD_REG_STATUS) ||
                 (wb_adr_i == `LPD_REG_ADDR_LO) || (wb_adr_i == `LPD_REG_ADDR_HI) ||
                 (wb_adr_i == `LPD_REG_ATTR);
   // =====================================================================
   // Decode of the stored entry
   wire sc = ctrl_ff[`LPD_CTL_SC];
   wire dt = ctrl_ff[`LPD_CTL_DT];
   wire zero_len_read_cap = ctrl_ff[`LPD_CTL_ZLR];
   wire second_level_exec_enable = ctrl_ff[`LPD_CTL_SECOND_LEVEL_EXEC_ENABLE];
   wire ext_mem_type_enable = ctrl_ff[`LPD_CTL_EXT_MEM_TYPE_ENABLE];
   wire pasid = ctrl_ff[`LPD_CTL_PASID];
   wire xlat = ctrl_ff[`LPD_CTL_XLAT];
   wire nested = ctrl_ff[`LPD_CTL_NESTED];
   wire cohdom = ctrl_ff[`LPD_CTL_COHDOM];
   wire ns_req = ctrl_ff[`LPD_CTL_NS];
   wire zlen = ctrl_ff[`LPD_CTL_ZLEN];
   wire is_wr = ctrl_ff[`LPD_CTL_ISWR];
   wire is_ex = ctrl_ff[`LPD_CTL_ISEX];
   wire leaf = entry_ff[`LPD_BIT_PS];
   wire force_snoop_bit = entry_ff[`LPD_BIT_SNP];
   wire tm = entry_ff[`LPD_BIT_TM];
   wire rd_bit = entry_ff[`LPD_BIT_READ];
   wire wr_bit = entry_ff[`LPD_BIT_WRITE];
   wire ex_bit = entry_ff[`LPD_BIT_EXEC];
   // Bits 10:8, 61:52 and 63 never feed any term below
   wire [63:0] hi_mask = ({64{1'b1}} << HOST_ADDR_WIDTH) & ~({64{1'b1}} << (`LPD_RSV_TOP + 1));
   wire rsv_hi = |(entry_ff & hi_mask);
   wire rsv_mid = |entry_ff[`LPD_RSV_HI:`LPD_RSV_LO];
   wire rsv_snp = ~sc & force_snoop_bit;
   wire rsv_tm = ~dt & tm;
   wire use_attr = ext_mem_type_enable & pasid & nested & cohdom;
   wire [2:0] mem_type;
   wire type_rsv;
   wire skip_pat;
   wire attr_on;
   lpd_memtype u_mt (
      .code_i(entry_ff[`LPD_EMT_HI:`LPD_EMT_LO]),
      .use_i(use_attr),
      .skip_pat_i(entry_ff[`LPD_BIT_SKIP_ATTR_TABLE_BIT]),
      .mem_type_o(mem_type),
      .type_rsv_o(type_rsv),
      .skip_attr_table_o(skip_pat),
      .apply_o(attr_on)
   );
   wire fault = leaf & (rsv_hi | rsv_mid | rsv_snp | rsv_tm | type_rsv);
   wire rd_ok = rd_bit | (zero_len_read_cap & zlen & (wr_bit | ex_bit));
   wire wr_ok = wr_bit;
   wire ex_ok = ~(second_level_exec_enable & ~ex_bit);
   wire need_rd = ~is_wr;
   wire perm_ok = (~need_rd | rd_ok) & (~is_wr | wr_ok) & (~is_ex | ex_ok);
   wire blocked = leaf & (fault | ~perm_ok);
   // Snoop enforcement; PASID requests always snoop
   wire do_snoop = pasid ? 1'b1 : ((sc & force_snoop_bit) | ~ns_req);
   wire n_field = pasid ? 1'b1 : (sc & force_snoop_bit);
   wire u_field = dt & tm;
   wire [63:0] nxt_addr_res = leaf ? ((entry_ff & ({64{1'b1}} << `LPD_ADDR_LO)) & ~hi_mask &
                              ~({64{1'b1}} << (`LPD_RSV_TOP + 1))) : 64'h0;
   // =====================================================================
   // Bus slave and result capture
   always @(posedge clk_i) begin
      if (rst_i) begin
         entry_ff <= 64'h0;
         ctrl_ff <= `LPD_CTL_RST;
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
         wb_dat_o <= 32'h0;
         addr_res_ff <= 64'h0;
         status_ff <= 32'h0;
         attr_ff <= 32'h0;
      end else begin
         ack_ff <= req & mapped;
         err_ff <= req & ~mapped;
         addr_res_ff <= nxt_addr_res;
         // Page table pointers give no leaf outputs except attr_on in bit 9 and skip_pat and mem_type in attr_ff
         status_ff <= {22'h0, attr_on, u_field & leaf, n_field & leaf, do_snoop & leaf,
                       ex_ok & leaf, wr_ok & leaf, rd_ok & leaf, blocked, fault,
                       ~leaf};
         attr_ff <= {28'h0, skip_pat, mem_type};
         if (req & wb_we_i) begin
            case (wb_adr_i)
               `LPD_REG_ENTRY_LO: begin
                  entry_ff[31:0] <= merge(entry_ff[31:0], wb_dat_i, wb_sel_i);
               end
               `LPD_REG_ENTRY_HI: begin
                  entry_ff[63:32] <= merge(entry_ff[63:32], wb_dat_i, wb_sel_i);
               end
               `LPD_REG_CTRL: begin
                  ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i) & 32'h0000_1fff;
               end
               default: begin
               end
            endcase
         end
         case (wb_adr_i)
            `LPD_REG_ENTRY_LO: wb_dat_o <= entry_ff[31:0];
            `LPD_REG_ENTRY_HI: wb_dat_o <= entry_ff[63:32];
            `LPD_REG_CTRL: wb_dat_o <= ctrl_ff;
            `LPD_REG_STATUS: wb_dat_o <= status_ff;
            `LPD_REG_ADDR_LO: wb_dat_o <= addr_res_ff[31:0];
            `LPD_REG_ADDR_HI: wb_dat_o <= addr_res_ff[63:32];
            `LPD_REG_ATTR: wb_dat_o <= attr_ff;
            default: wb_dat_o <= 32'h0;
         endcase
      end
   end
   assign wb_ack_o = ack_ff;
   assign wb_err_o = err_ff;
endmodule // lpd_decode

// ### verification/lpd_decode_chk.sv
module lpd_decode_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic req;
   logic mapped;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign mapped = (wb_adr_i <= 6'h18) && (wb_adr_i[1:0] == 2'h0);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // =====================================================
   // Bus answer timing
   ack_timing_a: assert property (req && mapped |=> wb_ack_o) else $error("ack late");
   err_timing_a: assert property (req && wb_adr_i > 6'h18 |=> wb_err_o) else $error("err late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   err_pulse_a: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
   one_answer_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
   err_data_a: assert property (wb_err_o |-> wb_dat_o == 32'h0) else $error("err data");
   no_spurious_a: assert property (wb_ack_o || wb_err_o |-> $past(req)) else $error("stray");
   // Reset must leave the bus quiet even while held
   reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !wb_err_o)
      else $error("answer in reset");
endmodule // lpd_decode_chk
bind lpd_decode lpd_decode_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o));

// ### verification/lpd_io_dev.sv
module lpd_io_dev (
   input wire logic [12:0] want_i,
   output logic [31:0] ctrl_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Zero-length request is a read, so write and fetch kinds drop
   assign ctrl_o = {19'h0, want_i[12:11] & {2{~want_i[10]}}, want_i[10:0]};
endmodule // lpd_io_dev

// ### verification/lpd_decode_tb_top.sv
module lpd_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] wdat = 32'h0;
   logic [12:0] want = 13'h0;
   logic [31:0] rdat, ctl, q;
   logic ack, err, e_seen;
   int failures = 0;
   int n_checks = 0;
   always #20 clk_i = ~clk_i;
   lpd_decode #(.HOST_ADDR_WIDTH(39)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err));
   lpd_io_dev dev_u (.want_i(want), .ctrl_o(ctl));
   // =====================================================
   // Tasks
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
      q = rdat;
      e_seen = err;
      if (ack !== 1'b1 && err !== 1'b1) begin
         failures++;
         wrap_up();
      end
      cyc <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g,
      input logic [31:0] m);
      n_checks++;
      if ((g & m) !== (e & m)) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e & m, g & m);
      end
   endtask
   // Control word reaches the model two bus cycles before it is written
   task automatic xcase(input logic [12:0] r, input logic [31:0] lo, input logic [31:0] hi,
      input logic [31:0] e, input logic [31:0] m);
      want <= r;
      bus(1'b1, 6'h04, hi);
      bus(1'b1, 6'h00, lo);
      bus(1'b1, 6'h08, ctl);
      bus(1'b0, 6'h0c, 32'h0);
      chk("status", e, q, m);
      $display("case %h %h done", r, lo);
   endtask
   // =====================================================
   // Scenarios
   initial begin
      logic v;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      xcase(13'h004b, 32'h34e00883, 32'h40000012, 32'h1d8, 32'h3ff);
      bus(1'b0, 6'h10, 32'h0);
      chk("addr_lo", 32'h34e00000, q, 32'hffffffff);
      bus(1'b0, 6'h14, 32'h0);
      chk("addr_hi", 32'h12, q, 32'hffffffff);
      xcase(13'h026b, 32'h34e00083, 32'h40000012, 32'h1d8, 32'h3ff);
      xcase(13'h024b, 32'h34e00083, 32'h40000012, 32'h118, 32'h3ff);
      xcase(13'h004a, 32'h34e00883, 32'h12, 32'h6, 32'h7);
      xcase(13'h004b, 32'h34e00003, 32'h12, 32'h1, 32'h1f9);
      xcase(13'h004b, 32'h34e01083, 32'h12, 32'h6, 32'h7);
      xcase(13'h004b, 32'h34e00083, 32'h80, 32'h6, 32'h7);
      xcase(13'h0049, 32'h34e00083, 32'h40000012, 32'h6, 32'h7);
      xcase(13'h004b, 32'h34e00783, 32'hc0000012, 32'h158, 32'h3ff);
      xcase(13'h004b, 32'h34e00082, 32'h12, 32'h4, 32'hc);
      xcase(13'h044f, 32'h34e00082, 32'h12, 32'h0, 32'h4);
      xcase(13'h084b, 32'h34e00081, 32'h12, 32'h4, 32'h14);
      xcase(13'h1043, 32'h34e00083, 32'h12, 32'h20, 32'h24);
      xcase(13'h104b, 32'h34e00083, 32'h12, 32'h4, 32'h24);
      for (int c = 0; c < 8; c++) begin
         v = (c < 2 || (c > 3 && c < 7));
         xcase(13'h01f3, 32'h34e00083 | (c << 3) | (c[0] << 6), 32'h12, {1'b1, 7'h0, ~v, 1'b0},
            32'h202);
         bus(1'b0, 6'h18, 32'h0);
         chk("attr", {c[0], c[2:0]}, q, v ? 32'hf : 32'h0);
      end
      xcase(13'h01e3, 32'h34e000f3, 32'h12, 32'h0, 32'h200);
      xcase(13'h0173, 32'h34e000f3, 32'h12, 32'h0, 32'h200);
      bus(1'b0, 6'h18, 32'h0);
      chk("attr_off", 32'h0, q, 32'hf);
      bus(1'b0, 6'h1c, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e_seen}, 32'hffffffff);
      wrap_up();
   end
endmodule // lpd_decode_tb_top
